// File: design/fir_avg_stage.sv
// one averaging stage of the cascaded fir, 2**b taps
module fir_avg_stage #(
   parameter int W    = 32,
   parameter int BMAX = 7
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [2:0]   size_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o
);
   localparam int D  = 2 ** BMAX;
   localparam int SW = W + BMAX;

   if (BMAX < 7 || W < 2) begin : g_chk
      $error("fir_avg_stage: BMAX must be at least 7, W at least 2");
   end

   typedef struct packed {
      logic [BMAX-1:0]        wp;
      logic [BMAX:0]          fill;
      logic [2:0]             b;
      logic signed [SW-1:0]   sum;
      logic                   ov;
      logic [W-1:0]           od;
   } stage_type;

   stage_type   st_reg;
   stage_type   st_next;
   logic [W-1:0] hist [0:D-1];
   logic [W-1:0] old_s;
   logic [BMAX:0] n_taps;

   assign n_taps = (BMAX+1)'(1) << st_reg.b;
   assign old_s  = hist[st_reg.wp - n_taps[BMAX-1:0]];

   // running sum over the last n samples, restarted on a size change
   always_comb begin
      st_next    = st_reg;
      st_next.ov = 1'b0;
      if (size_i != st_reg.b) begin
         st_next.b    = size_i;
         st_next.sum  = '0;
         st_next.fill = '0;
      end else if (in_valid_i) begin
         st_next.sum = st_reg.sum + SW'($signed(in_data_i));
         if (st_reg.fill >= n_taps) begin
            st_next.sum = st_next.sum - SW'($signed(old_s));
         end else begin
            st_next.fill = st_reg.fill + 1'b1;
         end
         st_next.wp = st_reg.wp + 1'b1;
         st_next.ov = 1'b1;
         st_next.od = W'(st_next.sum >>> st_reg.b);
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // sample history, no reset needed
   always_ff @(posedge sys_clk_i) begin
      if (in_valid_i && size_i == st_reg.b) begin
         hist[st_reg.wp] <= in_data_i;
      end
   end

   assign out_valid_o = st_reg.ov;
   assign out_data_o  = st_reg.od;

   a_stage_valid: assert property (@(posedge sys_clk_i)
      disable iff (sys_rst_i)
      in_valid_i && size_i == st_reg.b |=> out_valid_o)
      else $error("averaging stage dropped a sample");
endmodule

// File: design/imu_cfg_pkg.sv
// constants shared by the sample-clock and filter control block
package imu_cfg_pkg;
   // register byte addresses on the serial port
   localparam logic [6:0] ZA_LO_ADDR = 7'h54;
   localparam logic [6:0] ZA_HI_ADDR = 7'h56;
   localparam logic [6:0] FIR_ADDR   = 7'h5c;
   localparam logic [6:0] RANGE_ADDR = 7'h5e;
   localparam logic [6:0] MISC_ADDR  = 7'h60;
   localparam logic [6:0] MULT_ADDR  = 7'h62;
   localparam logic [6:0] DEC_ADDR   = 7'h64;
   // reset values
   localparam logic [15:0] ZA_RST   = 16'h0000;
   localparam logic [2:0]  FIR_RST  = 3'h0;
   localparam logic [7:0]  MISC_RST = 8'hc1;
   localparam logic [15:0] MULT_RST = 16'h07d0;
   localparam logic [10:0] DEC_RST  = 11'h000;
   // field positions
   localparam int MISC_LING_BIT = 7;
   localparam int MISC_POP_BIT  = 6;
   localparam int MISC_SYNC_LSB = 2;
   localparam int MISC_SPOL_BIT = 1;
   localparam int MISC_DPOL_BIT = 0;
   localparam int FIR_B_W       = 3;
   localparam int DEC_W         = 11;
   localparam logic [1:0] RANGE_RSVD = 2'h3;
   // sync function codes
   localparam logic [2:0] MODE_INT     = 3'h0;
   localparam logic [2:0] MODE_DIRECT  = 3'h1;
   localparam logic [2:0] MODE_SCALED  = 3'h2;
   localparam logic [2:0] MODE_OUTSYNC = 3'h3;
   localparam logic [2:0] MODE_PULSE   = 3'h5;
   // timing
   localparam int CLK_HZ        = 250_000_000;
   localparam int CLK_NS        = 4;
   localparam int INT_RATE_HZ   = 2000;
   localparam int ACC_RATE_HZ   = 4000;
   localparam int ACC_TICK_CYC  = CLK_HZ / ACC_RATE_HZ;
   localparam int PULSE_BW_HZ   = 370;
   localparam int SYNC_OUT_NS   = 400;
   localparam int SYNC_OUT_CYC  = SYNC_OUT_NS / CLK_NS;
   localparam int RDY_NS        = 1000;
   localparam int RDY_CYC       = RDY_NS / CLK_NS;
   localparam int SPI_BITS      = 16;
endpackage

// File: design/imu_sample_sync_filter_ctrl.sv
// sample clock, sync pin, filter and config registers of the imu
// What this block does
// - z accel offset upper word joins lower word as 32-bit bias
// - fir is two averaging stages of 2**b taps, b in bits 2:0
// - gyro range reads as 2-bit code, reserved field reads 11
// - misc bit 7 enables linear-g gyro compensation
// - misc bit 6 enables point-of-percussion alignment
// - bits 4:2 pick internal, direct, scaled, output or pulse sync
// - bit 1 picks rising or falling sync edge, in and out
// - bit 0 picks data-ready polarity
// - misc register resets to 0x00c1
// - internal mode runs at 2000 Hz from two 4000 Hz samples
// - output sync mode pulses sync pin at each collection
// - direct sync samples both edges and averages each pair
// - pulse sync samples leading edge only, bandwidth 370 Hz
// - scaled sync sample rate is sync rate times multiplier
// - output rate is sample rate over decimation divisor plus one
module imu_sample_sync_filter_ctrl #(
   parameter int         ACC_TICK_CYC = imu_cfg_pkg::ACC_TICK_CYC,
   parameter logic [1:0] GYRO_RANGE   = 2'h3
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        cs_n_i,
   input  wire logic        sclk_i,
   input  wire logic        din_i,
   output logic             dout_o,
   input  wire logic        sync_i,
   output logic             sync_o,
   output logic             sync_oe_n_o,
   input  wire logic [31:0] accel_z_i,
   output logic [31:0]      accel_z_o,
   output logic             data_ready_pin_o,
   output logic             lin_g_comp_en_o,
   output logic             pop_align_en_o,
   output logic             bw_reduced_o
);
   if (ACC_TICK_CYC < 2 || GYRO_RANGE == 2'h2) begin : g_chk
      $error("bad tick count or reserved gyro range code");
   end

   typedef struct packed {
      logic [15:0] za_lo;
      logic [15:0] za_hi;
      logic [2:0]  fir;
      logic [7:0]  misc;
      logic [15:0] mult;
      logic [10:0] dec;
      logic        sclk_d;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [4:0]  bitcnt;
      logic [6:0]  rd_addr;
      logic        dout;
      logic        sync_d;
      logic [31:0] div_cnt;
      logic        half;
      logic [31:0] s0;
      logic [31:0] per_cnt;
      logic [31:0] period;
      logic        per_ok;
      logic [31:0] acc;
      logic        upd_v;
      logic [31:0] upd_d;
      logic [10:0] dec_cnt;
      logic [31:0] out_d;
      logic [15:0] rdy_cnt;
      logic        rdy;
      logic [15:0] so_cnt;
      logic        so;
      logic        so_oe_n;
      logic        ling;
      logic        pop;
      logic        bw_red;
   } ctrl_type;

   ctrl_type    st_reg;
   ctrl_type    st_next;
   logic        s1_v;
   logic [31:0] s1_d;
   logic        s2_v;
   logic [31:0] s2_d;

   // two cascaded averaging stages sharing the tap-size field
   fir_avg_stage #(.W(32), .BMAX(7)) u_stage1 (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .size_i      (st_reg.fir),
      .in_valid_i  (st_reg.upd_v),
      .in_data_i   (st_reg.upd_d),
      .out_valid_o (s1_v),
      .out_data_o  (s1_d)
   );
   fir_avg_stage #(.W(32), .BMAX(7)) u_stage2 (
      .sys_clk_i   (sys_clk_i),
      .sys_rst_i   (sys_rst_i),
      .size_i      (st_reg.fir),
      .in_valid_i  (s1_v),
      .in_data_i   (s1_d),
      .out_valid_o (s2_v),
      .out_data_o  (s2_d)
   );

   // merge one written byte into a 16-bit register
   function automatic logic [15:0] put_byte(input logic [15:0] old,
                                            input logic hi,
                                            input logic [7:0] b);
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
   endfunction

   // register read mux, unmapped words read as zero
   function automatic logic [15:0] rd_word(input ctrl_type s,
                                           input logic [6:0] a);
      rd_word = 16'h0000;
      case ({a[6:1], 1'b0})
         imu_cfg_pkg::ZA_LO_ADDR: rd_word = s.za_lo;
         imu_cfg_pkg::ZA_HI_ADDR: rd_word = s.za_hi;
         imu_cfg_pkg::FIR_ADDR:   rd_word = {13'h0, s.fir};
         imu_cfg_pkg::RANGE_ADDR:
            rd_word = {12'h0, GYRO_RANGE, imu_cfg_pkg::RANGE_RSVD};
         imu_cfg_pkg::MISC_ADDR:  rd_word = {8'h0, s.misc};
         imu_cfg_pkg::MULT_ADDR:  rd_word = s.mult;
         imu_cfg_pkg::DEC_ADDR:   rd_word = {5'h0, s.dec};
         default:                 rd_word = 16'h0000;
      endcase
   endfunction

   logic [2:0]  mode;
   logic        spol;
   logic        lead;
   logic        any_edge;
   logic        tick;
   logic        pair;
   logic [32:0] pair_sum;
   logic [31:0] raw;
   logic [15:0] word;
   logic [6:0]  wa;

   assign mode = st_reg.misc[imu_cfg_pkg::MISC_SYNC_LSB +: 3];
   assign spol = st_reg.misc[imu_cfg_pkg::MISC_SPOL_BIT];

   always_comb begin
      st_next       = st_reg;
      st_next.upd_v = 1'b0;
      tick          = 1'b0;
      pair          = 1'b0;
      raw           = accel_z_i;
      word          = {st_reg.rx[14:0], din_i};
      wa            = word[14:8];
      // serial port: sample on rising sclk, shift out on falling
      st_next.sclk_d = sclk_i;
      if (cs_n_i) begin
         st_next.bitcnt = '0;
         st_next.tx     = rd_word(st_reg, st_reg.rd_addr);
         st_next.dout   = st_next.tx[15];
      end else if (sclk_i && !st_reg.sclk_d) begin
         st_next.rx     = word;
         st_next.bitcnt = st_reg.bitcnt + 1'b1;
         if (st_reg.bitcnt == 5'(imu_cfg_pkg::SPI_BITS - 1)) begin
            st_next.bitcnt = '0;
            if (word[15]) begin
               case ({wa[6:1], 1'b0})
                  imu_cfg_pkg::ZA_LO_ADDR:
                     st_next.za_lo = put_byte(st_reg.za_lo, wa[0],
                                              word[7:0]);
                  imu_cfg_pkg::ZA_HI_ADDR:
                     st_next.za_hi = put_byte(st_reg.za_hi, wa[0],
                                              word[7:0]);
                  imu_cfg_pkg::FIR_ADDR:
                     if (!wa[0]) st_next.fir = word[2:0];
                  imu_cfg_pkg::MISC_ADDR:
                     if (!wa[0]) st_next.misc = word[7:0];
                  imu_cfg_pkg::MULT_ADDR:
                     st_next.mult = put_byte(st_reg.mult, wa[0],
                                             word[7:0]);
                  imu_cfg_pkg::DEC_ADDR:
                     st_next.dec = 11'(put_byte({5'h0, st_reg.dec},
                                                wa[0], word[7:0]));
                  default: ;
               endcase
            end else begin
               st_next.rd_addr = wa;
            end
         end
      end else if (!sclk_i && st_reg.sclk_d && st_reg.bitcnt != 0) begin
         st_next.tx   = {st_reg.tx[14:0], 1'b0};
         st_next.dout = st_reg.tx[14];
      end
      // sync pin edges, leading edge set by polarity
      st_next.sync_d = sync_i;
      any_edge = sync_i ^ st_reg.sync_d;
      lead = any_edge && (sync_i == spol);
      // sample clock selection
      case (mode)
         imu_cfg_pkg::MODE_INT, imu_cfg_pkg::MODE_OUTSYNC: begin
            st_next.div_cnt = st_reg.div_cnt + 1'b1;
            if (st_reg.div_cnt >= 32'(ACC_TICK_CYC - 1)) begin
               st_next.div_cnt = '0;
               tick = 1'b1;
            end
            pair = 1'b1;
         end
         imu_cfg_pkg::MODE_DIRECT: begin
            tick = any_edge;
            pair = 1'b1;
         end
         imu_cfg_pkg::MODE_PULSE: begin
            tick = lead;
         end
         imu_cfg_pkg::MODE_SCALED: begin
            // k ticks per measured sync period, no divider needed
            st_next.per_cnt = st_reg.per_cnt + 1'b1;
            if (lead) begin
               st_next.period  = st_reg.per_cnt + 1'b1;
               st_next.per_cnt = '0;
               st_next.per_ok  = 1'b1;
            end
            st_next.acc = st_reg.acc + 32'(st_reg.mult);
            if (st_reg.per_ok && st_next.acc >= st_reg.period) begin
               st_next.acc = st_next.acc - st_reg.period;
               tick = 1'b1;
            end
         end
         default: ;
      endcase
      pair_sum = {st_reg.s0[31], st_reg.s0} + {raw[31], raw};
      // collect one update per tick, or per pair of ticks
      if (tick) begin
         if (pair) begin
            st_next.half = !st_reg.half;
            st_next.s0   = raw;
            if (st_reg.half) begin
               st_next.upd_v = 1'b1;
               st_next.upd_d = pair_sum[32:1]
                             + {st_reg.za_hi, st_reg.za_lo};
            end
         end else begin
            st_next.upd_v = 1'b1;
            st_next.upd_d = raw + {st_reg.za_hi, st_reg.za_lo};
         end
      end
      // decimation after the second stage, ready width counts every cycle
      if (st_reg.rdy_cnt != 0) begin
         st_next.rdy_cnt = st_reg.rdy_cnt - 1'b1;
      end
      if (s2_v) begin
         st_next.dec_cnt = st_reg.dec_cnt + 1'b1;
         if (st_reg.dec_cnt >= st_reg.dec) begin
            st_next.dec_cnt = '0;
            st_next.out_d   = s2_d;
            st_next.rdy_cnt = 16'(imu_cfg_pkg::RDY_CYC);
         end
      end
      st_next.rdy = (st_next.rdy_cnt != 0)
                  == st_next.misc[imu_cfg_pkg::MISC_DPOL_BIT];
      // sync pulse out at each collection in output sync mode
      if (st_next.upd_v && mode == imu_cfg_pkg::MODE_OUTSYNC) begin
         st_next.so_cnt = 16'(imu_cfg_pkg::SYNC_OUT_CYC);
      end else if (st_reg.so_cnt != 0) begin
         st_next.so_cnt = st_reg.so_cnt - 1'b1;
      end
      st_next.so      = (st_next.so_cnt != 0) == spol;
      st_next.so_oe_n = mode != imu_cfg_pkg::MODE_OUTSYNC;
      st_next.ling    = st_next.misc[imu_cfg_pkg::MISC_LING_BIT];
      st_next.pop     = st_next.misc[imu_cfg_pkg::MISC_POP_BIT];
      st_next.bw_red  = mode == imu_cfg_pkg::MODE_PULSE;
   end

   // state register, reset values per register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_reg         <= '0;
         st_reg.za_lo   <= imu_cfg_pkg::ZA_RST;
         st_reg.za_hi   <= imu_cfg_pkg::ZA_RST;
         st_reg.fir     <= imu_cfg_pkg::FIR_RST;
         st_reg.misc    <= imu_cfg_pkg::MISC_RST;
         st_reg.mult    <= imu_cfg_pkg::MULT_RST;
         st_reg.dec     <= imu_cfg_pkg::DEC_RST;
         st_reg.sclk_d  <= 1'b1;
         st_reg.rdy     <= 1'b0;
         st_reg.so      <= 1'b0;
         st_reg.so_oe_n <= 1'b1;
         st_reg.ling    <= 1'b1;
         st_reg.pop     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout_o           = st_reg.dout;
   assign sync_o           = st_reg.so;
   assign sync_oe_n_o      = st_reg.so_oe_n;
   assign accel_z_o        = st_reg.out_d;
   assign data_ready_pin_o = st_reg.rdy;
   assign lin_g_comp_en_o  = st_reg.ling;
   assign pop_align_en_o   = st_reg.pop;
   assign bw_reduced_o     = st_reg.bw_red;

   // checks on the registered behaviour
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_misc_reset: assert property ($past(sys_rst_i) |->
      st_reg.misc == 8'hc1 && lin_g_comp_en_o && pop_align_en_o)
      else $error("misc control not at reset value");
   a_ling_follow: assert property (
      lin_g_comp_en_o == $past(st_next.misc[7]))
      else $error("linear-g enable does not follow bit 7");
   a_pop_follow: assert property (
      ##1 pop_align_en_o == $past(st_reg.misc[6], 1) || $changed(st_reg.misc))
      else $error("alignment enable does not follow bit 6");
   a_rdy_level: assert property (
      data_ready_pin_o == ((st_reg.rdy_cnt != 0) == st_reg.misc[0]))
      else $error("data ready polarity wrong");
   a_bias_apply: assert property (
      tick && !pair |=> st_reg.upd_v &&
      st_reg.upd_d == $past(accel_z_i) + $past({st_reg.za_hi, st_reg.za_lo}))
      else $error("bias not applied to sample");
   a_sync_drive: assert property (
      !sync_oe_n_o |-> $past(mode) == 3'h3)
      else $error("sync pin driven outside output sync mode");
   a_pulse_bw: assert property (
      mode == 3'h5 |=> bw_reduced_o)
      else $error("bandwidth not reduced in pulse sync");
   a_direct_edge: assert property (
      mode == 3'h1 && !any_edge && $stable(mode) |=> !st_reg.upd_v)
      else $error("direct sync update without a pin edge");
   a_range_read: assert property (
      cs_n_i && st_reg.rd_addr == 7'h5e |=> st_reg.tx[1:0] == 2'h3)
      else $error("range register reserved field not 11");

   c_int_upd:  cover property (mode == 3'h0 && st_reg.upd_v);
   c_scaled:   cover property (mode == 3'h2 && st_reg.upd_v);
   c_out_sync: cover property (!sync_oe_n_o && $changed(sync_o));
   c_rdy_pulse: cover property ($rose(st_reg.rdy_cnt != 0));
endmodule

// File: sim/imu_host_model.sv
// host serial master and external sync source facing the imu block
module imu_host_model (
   input  wire logic clk_i,
   input  wire logic dout_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      din_o,
   output logic      sync_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int sync_kind = 0;  // 0 idle, 1 square wave, 2 narrow pulses
   int sync_per  = 40;
   // idle levels: chip deselected, serial clock high
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      din_o  = 1'b0;
   end
   // one 16-bit frame, each serial clock phase three clocks long
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (3) @(negedge clk_i);
         sclk_o = 1'b0;
         din_o  = w[i];
         repeat (3) @(negedge clk_i);
         r[i]   = dout_i;
         sclk_o = 1'b1;
      end
      repeat (3) @(negedge clk_i);
      cs_n_o = 1'b1;
      din_o  = ~din_o;  // released data line does not keep its value
      repeat (4) @(negedge clk_i);
   endtask
   // register write as two byte frames, low byte first
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] r;
      if (a == imu_cfg_pkg::MISC_ADDR) d[5] = 1'b0;
      xfer({1'b1, a & 7'h7e, d[7:0]}, r);
      xfer({1'b1, a | 7'h01, d[15:8]}, r);
   endtask
   // register read: data comes back in the following frame
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      logic [15:0] r;
      xfer({1'b0, a, 8'h00}, r);
      xfer({1'b0, a, 8'h00}, d);
   endtask
   // external sync: 50% duty square wave or narrow pulse train
   always begin
      if (sync_kind == 1) begin
         repeat (sync_per / 2) @(negedge clk_i);
         sync_o = ~sync_o;
      end else if (sync_kind == 2) begin
         repeat (sync_per - 4) @(negedge clk_i);
         sync_o = 1'b1;
         repeat (4) @(negedge clk_i);
         sync_o = 1'b0;
      end else begin
         sync_o = 1'b0;
         @(negedge clk_i);
      end
   end
endmodule

// File: sim/tb.sv
// self-checking bench for the sample clock and filter control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 64;
   localparam int UPD  = 2 * TICK;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cs_n, sclk, din, dout, ext_sync, sync_out, sync_oe_n;
   logic        drdy, lin_g, pop, bw_red, sync_pin, drdy_n, sync_n;
   logic [31:0] acc_in;
   logic [31:0] acc_out;
   int          errors = 0;
   int          check_count = 0;
   // shared sync wire and inverted views for active-low measurements
   assign sync_pin = sync_oe_n ? ext_sync : sync_out;
   assign drdy_n   = ~drdy;
   assign sync_n   = ~sync_out;
   // z sample follows the external sync level so paired edges differ
   assign acc_in   = ext_sync ? 32'h0000_1400 : 32'h0000_0c00;
   // 250 MHz clock
   always #2 clk = ~clk;
   imu_host_model u_host (
      .clk_i (clk),
      .dout_i(dout),
      .cs_n_o(cs_n),
      .sclk_o(sclk),
      .din_o (din),
      .sync_o(ext_sync)
   );
   imu_sample_sync_filter_ctrl #(
      .ACC_TICK_CYC(TICK),
      .GYRO_RANGE  (2'h3)
   ) u_dut (
      .sys_clk_i       (clk),
      .sys_rst_i       (rst),
      .cs_n_i          (cs_n),
      .sclk_i          (sclk),
      .din_i           (din),
      .dout_o          (dout),
      .sync_i          (sync_pin),
      .sync_o          (sync_out),
      .sync_oe_n_o     (sync_oe_n),
      .accel_z_i       (acc_in),
      .accel_z_o       (acc_out),
      .data_ready_pin_o(drdy),
      .lin_g_comp_en_o (lin_g),
      .pop_align_en_o  (pop),
      .bw_reduced_o    (bw_red)
   );
   // compare one value, count it, report a mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] d;
      u_host.rd(a, d);
      chk({16'h0, d}, {16'h0, exp});
   endtask
   // cycles until the next rising edge of a signal, bounded
   task automatic rise(ref logic s, output int cyc);
      logic p;
      p = s;
      for (cyc = 1; cyc < 5000; cyc++) begin
         @(negedge clk);
         if (s === 1'b1 && p === 1'b0) break;
         p = s;
      end
   endtask
   // settle, then compare one full period between rising edges
   task automatic period(ref logic s, input int exp);
      int c;
      repeat (3) rise(s, c);
      rise(s, c);
      chk(c, exp);
   endtask
   task automatic t_reset();
      rdchk(imu_cfg_pkg::MISC_ADDR, 16'h00c1);
      rdchk(imu_cfg_pkg::MULT_ADDR, 16'h07d0);
      rdchk(imu_cfg_pkg::ZA_HI_ADDR, 16'h0000);
      rdchk(imu_cfg_pkg::FIR_ADDR, 16'h0000);
      rdchk(imu_cfg_pkg::RANGE_ADDR, 16'h000f);
      rdchk(imu_cfg_pkg::ZA_LO_ADDR, 16'h0000);
      chk({30'h0, lin_g, pop}, 32'h3);
      $display("test reset done");
   endtask
   task automatic t_regs();
      u_host.wr(imu_cfg_pkg::RANGE_ADDR, 16'h1234);
      rdchk(imu_cfg_pkg::RANGE_ADDR, 16'h000f);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h0041);
      chk({30'h0, lin_g, pop}, 32'h1);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h0081);
      chk({30'h0, lin_g, pop}, 32'h2);
      rdchk(imu_cfg_pkg::MISC_ADDR, 16'h0081);
      u_host.wr(imu_cfg_pkg::FIR_ADDR, 16'h0007);
      rdchk(imu_cfg_pkg::FIR_ADDR, 16'h0007);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00c1);
      $display("test registers done");
   endtask
   task automatic t_internal();
      u_host.wr(imu_cfg_pkg::FIR_ADDR, 16'h0000);
      u_host.wr(imu_cfg_pkg::ZA_HI_ADDR, 16'h0002);
      u_host.wr(imu_cfg_pkg::ZA_LO_ADDR, 16'h0003);
      u_host.wr(imu_cfg_pkg::DEC_ADDR, 16'h0003);
      period(drdy, UPD * 4);
      chk(acc_out, 32'h0002_0c03);
      u_host.wr(imu_cfg_pkg::FIR_ADDR, 16'h0002);
      period(drdy, UPD * 4);
      period(drdy, UPD * 4);
      chk(acc_out, 32'h0002_0c03);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00c0);
      period(drdy_n, UPD * 4);
      chk({31'h0, sync_oe_n}, 32'h1);
      $display("test internal done");
   endtask
   task automatic t_outsync();
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00cf);
      chk({31'h0, sync_oe_n}, 32'h0);
      period(sync_out, UPD);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00cd);
      period(sync_n, UPD);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00c1);
      chk({31'h0, sync_oe_n}, 32'h1);
      $display("test output sync done");
   endtask
   task automatic t_ext();
      u_host.sync_per  = 80;
      u_host.sync_kind = 1;
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00c5);
      period(drdy, 4 * 80);
      chk(acc_out, 32'h0002_1003);
      u_host.sync_per  = 100;
      u_host.sync_kind = 2;
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00d7);
      chk({31'h0, bw_red}, 32'h1);
      period(drdy, 4 * 100);
      chk(acc_out, 32'h0002_1403);
      u_host.sync_per  = 400;
      u_host.sync_kind = 1;
      u_host.wr(imu_cfg_pkg::MULT_ADDR, 16'h0004);
      u_host.wr(imu_cfg_pkg::MISC_ADDR, 16'h00c9);
      chk({31'h0, bw_red}, 32'h0);
      period(drdy, 400 * 4 / 4);
      $display("test external sync done");
   endtask
   // counts and verdict, the one place where the run ends
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog sized well beyond the expected run length
   initial begin
      repeat (80000) @(posedge clk);
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, 32'h0, 32'h1);
      summarize();
   end
   // main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_regs();
      t_internal();
      t_outsync();
      t_ext();
      summarize();
   end
endmodule
